// [rtl/csr_pkg.sv]
/*
 package for the host-side controller of a strobe-clocked 4096x1 static memory.
 assumes a 10 MHz system clock; all memory timing is counted in its cycles.
*/
package csr_pkg;
  localparam int unsigned CLK_NS = 100;
  localparam int unsigned ADDR_W = 12;
  // timing figures in ns (slowest grade) and derived counts, least times round up
  localparam int unsigned ACCESS_DELAY_NS = 500;
  localparam int unsigned STROBE_LOW_TIME_NS = 500;
  localparam int unsigned WRITE_PULSE_WIDTH_NS = 200;
  localparam int unsigned OUTPUT_TURNOFF_DELAY_NS = 200;
  localparam int unsigned OE_SETUP_NS = 90;
  localparam int unsigned ACCESS_CYC = (ACCESS_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PRESET_CYC = (STROBE_LOW_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WPULSE_CYC = (WRITE_PULSE_WIDTH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TURNOFF_CYC = (OUTPUT_TURNOFF_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned OESU_CYC = (OE_SETUP_NS + CLK_NS - 1) / CLK_NS;
  // latency of the two-flop pin synchronisers on data and flag
  localparam int unsigned SYNC_CYC = 2;
  localparam int unsigned CNT_W = 4;

  typedef enum logic [1:0] {CSR_OP_READ, CSR_OP_WRITE, CSR_OP_RMW} csr_op_t;

  typedef enum {
    CSR_ST_INIT, CSR_ST_IDLE, CSR_ST_ACCESS, CSR_ST_WRITE, CSR_ST_TURNOFF,
    CSR_ST_WDRIVE, CSR_ST_PRESET
  } csr_state_t;

  typedef struct packed {
    csr_op_t op;
    logic [ADDR_W-1:0] addr;
    logic wdata;
  } csr_req_t;

  typedef struct packed {
    logic strobe;
    logic sel;
    logic wr_n;
    logic oe;
    logic out_off_ctl;
    logic [ADDR_W-1:0] addr;
    logic din;
    logic din_oen;
  } csr_pins_t;
endpackage : csr_pkg

// [rtl/csr_host.sv]
/*
 host controller driving a strobe-clocked 4096x1 static memory over its pins.
 assumes the memory shares one data pin for in and out; the pin is split into
 input, output and active-low output enable; the bench resolves the wire.
*/
`timescale 1ns/100ps
module csr_host (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // request side
  input wire logic i_req_valid,
  input csr_pkg::csr_req_t i_req,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic o_rsp_data,
  // memory pins
  output csr_pkg::csr_pins_t o_pins,
  input wire logic i_dout,
  input wire logic i_cycle_progress_flag
);
  typedef struct packed {
    csr_pkg::csr_state_t st;
    logic [csr_pkg::CNT_W-1:0] cnt;
    csr_pkg::csr_req_t req;
    csr_pkg::csr_pins_t pins;
    logic rsp_valid;
    logic rsp_data;
    logic flag_seen;
    logic early_write;
  } csr_regs_t;

  logic rst_s1, rst_s2;
  logic dout_s1, dout_s2, flag_s1, flag_s2;
  csr_regs_t s_r, s_nxt;

  localparam logic [csr_pkg::CNT_W-1:0] PRESET_INIT = csr_pkg::PRESET_CYC[csr_pkg::CNT_W-1:0];

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // pin inputs are asynchronous to i_mclk
  always_ff @(posedge i_mclk or negedge rst_s2) begin
    if (!rst_s2) begin
      dout_s1 <= 1'b0;
      dout_s2 <= 1'b0;
      flag_s1 <= 1'b0;
      flag_s2 <= 1'b0;
    end else begin
      dout_s1 <= i_dout;
      dout_s2 <= dout_s1;
      flag_s1 <= i_cycle_progress_flag;
      flag_s2 <= flag_s1;
    end
  end

  function automatic logic [csr_pkg::CNT_W-1:0] cyc(input int unsigned n);
    return n[csr_pkg::CNT_W-1:0];
  endfunction : cyc

  always_comb begin
    s_nxt = s_r;
    s_nxt.rsp_valid = 1'b0;
    if (s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
    case (s_r.st)
      csr_pkg::CSR_ST_INIT: begin
        // strobe low for a full preset before first cycle
        if (s_r.cnt == '0) begin
          s_nxt.st = csr_pkg::CSR_ST_IDLE;
        end
      end
      csr_pkg::CSR_ST_IDLE: begin
        // also wait for flag low: preset done
        if (i_req_valid && !flag_s2) begin
          s_nxt.req = i_req;
          s_nxt.pins.addr = i_req.addr;
          s_nxt.pins.sel = 1'b1;
          s_nxt.pins.strobe = 1'b1;
          // plain write: write line low at strobe rise, data already stable
          s_nxt.early_write = (i_req.op == csr_pkg::CSR_OP_WRITE);
          s_nxt.pins.wr_n = !(i_req.op == csr_pkg::CSR_OP_WRITE);
          s_nxt.pins.din = i_req.wdata;
          s_nxt.pins.din_oen = !(i_req.op == csr_pkg::CSR_OP_WRITE);
          s_nxt.pins.oe = (i_req.op != csr_pkg::CSR_OP_WRITE);
          s_nxt.pins.out_off_ctl = (i_req.op == csr_pkg::CSR_OP_WRITE);
          s_nxt.flag_seen = 1'b0;
          // synchroniser lag added so the timed-out path still sees settled data
          s_nxt.cnt = cyc(csr_pkg::ACCESS_CYC + csr_pkg::SYNC_CYC);
          s_nxt.st = csr_pkg::CSR_ST_ACCESS;
        end
      end
      csr_pkg::CSR_ST_ACCESS: begin
        if (flag_s2) begin
          s_nxt.flag_seen = 1'b1;
        end
        // access time or flag rise, whichever first; flag valid for early write
        if (s_r.cnt == '0 ||
            (flag_s2 && (s_r.early_write || s_r.req.op != csr_pkg::CSR_OP_WRITE))) begin
          if (s_r.req.op == csr_pkg::CSR_OP_RMW) begin
            s_nxt.rsp_data = dout_s2;
            s_nxt.rsp_valid = 1'b1;
            s_nxt.pins.oe = 1'b0;
            s_nxt.pins.out_off_ctl = 1'b1;
            s_nxt.cnt = cyc(csr_pkg::TURNOFF_CYC);
            s_nxt.st = csr_pkg::CSR_ST_TURNOFF;
          end else if (s_r.req.op == csr_pkg::CSR_OP_WRITE) begin
            // data held the full pulse from the strobe rise
            s_nxt.cnt = cyc(csr_pkg::WPULSE_CYC);
            s_nxt.st = csr_pkg::CSR_ST_WRITE;
          end else begin
            s_nxt.rsp_data = dout_s2;
            s_nxt.rsp_valid = 1'b1;
            s_nxt.pins.strobe = 1'b0;
            // buffer off through the preset, so a following write never meets it
            s_nxt.pins.oe = 1'b0;
            s_nxt.pins.out_off_ctl = 1'b1;
            s_nxt.cnt = cyc(csr_pkg::PRESET_CYC);
            s_nxt.st = csr_pkg::CSR_ST_PRESET;
          end
        end
      end
      csr_pkg::CSR_ST_TURNOFF: begin
        // keep off the shared pin until the memory buffer is off
        if (s_r.cnt == '0) begin
          s_nxt.pins.din = s_r.req.wdata;
          s_nxt.pins.din_oen = 1'b0;
          s_nxt.pins.wr_n = 1'b0;
          s_nxt.early_write = 1'b0;
          s_nxt.cnt = cyc(csr_pkg::WPULSE_CYC);
          s_nxt.st = csr_pkg::CSR_ST_WDRIVE;
        end
      end
      csr_pkg::CSR_ST_WDRIVE, csr_pkg::CSR_ST_WRITE: begin
        // pulse and data set-up counted to the write end
        if (s_r.cnt == '0) begin
          s_nxt.pins.wr_n = 1'b1;
          s_nxt.st = csr_pkg::CSR_ST_PRESET;
          s_nxt.cnt = cyc(csr_pkg::OESU_CYC);
        end
      end
      csr_pkg::CSR_ST_PRESET: begin
        if (s_r.pins.strobe) begin
          // write ended by write line one cycle before; data hold zero
          s_nxt.pins.strobe = 1'b0;
          s_nxt.cnt = cyc(csr_pkg::PRESET_CYC);
        end else if (s_r.cnt == '0 || (s_r.flag_seen && !flag_s2)) begin
          s_nxt.pins.din_oen = 1'b1;
          s_nxt.pins.sel = 1'b0;
          s_nxt.pins.oe = 1'b0;
          s_nxt.pins.out_off_ctl = 1'b1;
          s_nxt.st = csr_pkg::CSR_ST_IDLE;
        end
      end
      default: s_nxt.st = csr_pkg::CSR_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge rst_s2) begin
    if (!rst_s2) begin
      s_r <= '{st: csr_pkg::CSR_ST_INIT, cnt: PRESET_INIT, req: '0,
               pins: '{strobe: 1'b0, sel: 1'b0, wr_n: 1'b1, oe: 1'b0,
                       out_off_ctl: 1'b1, addr: 12'h000, din: 1'b0, din_oen: 1'b1},
               rsp_valid: 1'b0, rsp_data: 1'b0, flag_seen: 1'b0, early_write: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_req_ready = (s_r.st == csr_pkg::CSR_ST_IDLE) && !flag_s2;
  assign o_rsp_valid = s_r.rsp_valid;
  assign o_rsp_data = s_r.rsp_data;
  assign o_pins = s_r.pins;
endmodule : csr_host

// [tb/csr_host_assertions.sv]
/*
 pin checker beside the host controller.
 assumes it is bound to csr_host and sees only its ports.
*/
`timescale 1ns/100ps
module csr_host_assertions (
  // host ports
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_req_valid,
  input csr_pkg::csr_req_t i_req,
  input wire logic o_req_ready,
  input wire logic o_rsp_valid,
  input wire logic o_rsp_data,
  input csr_pkg::csr_pins_t o_pins,
  input wire logic i_dout,
  input wire logic i_cycle_progress_flag
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  sequence s_wr_low; !o_pins.wr_n ##1 !o_pins.wr_n; endsequence
  property p_preset; $rose(i_rstn) |-> !o_pins.strobe [*6]; endproperty
  a_preset: assert property (p_preset) else $error("strobe left preset early");
  property p_sel; $rose(o_pins.strobe) |-> o_pins.sel; endproperty
  a_sel: assert property (p_sel) else $error("select late");
  property p_next; $rose(o_pins.strobe) |-> !$past(i_cycle_progress_flag, 3); endproperty
  a_next: assert property (p_next) else $error("cycle before flag fell");
  property p_high; $rose(o_pins.strobe) |-> o_pins.strobe [*3]; endproperty
  a_high: assert property (p_high) else $error("strobe high too short");
  property p_wpul; $fell(o_pins.wr_n) |-> s_wr_low ##1 o_pins.strobe; endproperty
  a_wpul: assert property (p_wpul) else $error("write pulse short");
  property p_wend;
    $rose(o_pins.wr_n) |-> !$past(o_pins.wr_n, 2) && !$past(o_pins.din_oen, 2) &&
      ($past(o_pins.din) == $past(o_pins.din, 2));
  endproperty
  a_wend: assert property (p_wend) else $error("data not set before write end");
  property p_turn; $fell(o_pins.din_oen) |-> $past(!o_pins.oe, 2); endproperty
  a_turn: assert property (p_turn) else $error("bus drive before turn-off");
  property p_rd; o_rsp_valid |-> $past(o_pins.oe && !o_pins.out_off_ctl); endproperty
  a_rd: assert property (p_rd) else $error("read with buffer off");
endmodule : csr_host_assertions

bind csr_host csr_host_assertions chk_u (.i_mclk(i_mclk), .i_rstn(i_rstn),
  .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
  .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data), .o_pins(o_pins),
  .i_dout(i_dout), .i_cycle_progress_flag(i_cycle_progress_flag));

// [tb/csr_mem_model.sv]
/*
 behavioural 4096x1 strobe-clocked memory at the far side.
 assumes its pins are sampled on the bench clock; i_acc sets access speed.
*/
`timescale 1ns/100ps
module csr_mem_model (
  // host pins and data wire
  input wire logic i_mclk,
  input csr_pkg::csr_pins_t i_pins,
  input wire logic i_dq,
  input wire logic [2:0] i_acc,
  // memory outputs
  output logic o_dq,
  output logic o_flag
);
  logic mem [4096];
  logic [11:0] a = '0;
  logic sel = 0, dreg = 0, vld = 0, stb = 0, ql = 0, flg = 0;
  int cnt = 0;
  wire en = sel && vld && i_pins.oe && !i_pins.out_off_ctl;
  // released wire toggles so a stale bit never passes
  assign o_dq = en ? dreg : !ql;
  assign o_flag = flg;
  always @(posedge i_mclk) begin
    stb <= i_pins.strobe;
    ql <= o_dq;
    cnt <= (i_pins.strobe != stb) ? 1 : cnt + 1;
    if (i_pins.strobe && !stb) begin
      a <= i_pins.addr;
      sel <= i_pins.sel;
      vld <= 0;
      dreg <= 0;
    end else if (i_pins.strobe && cnt >= i_acc) begin
      flg <= 1;
      vld <= 1;
      dreg <= mem[a];
    end else if (!i_pins.strobe && !en) dreg <= 0;
    if (!i_pins.strobe && !stb && cnt >= i_acc) flg <= 0;
    if (i_pins.strobe && stb && sel && !i_pins.wr_n) mem[a] <= i_dq;
  end
endmodule : csr_mem_model

// [tb/csr_host_tb.sv]
/*
 self-checking bench for the host controller with a memory model.
 assumes a 10 MHz clock; inputs change on the falling edge.
*/
`timescale 1ns/100ps
module csr_host_tb;
  logic i_mclk = 0;
  logic i_rstn = 0;
  logic i_req_valid = 0;
  csr_pkg::csr_req_t i_req = '0;
  logic [2:0] acc = 3'h1;
  logic o_req_ready, o_rsp_valid, o_rsp_data, mdq, flag;
  csr_pkg::csr_pins_t o_pins;
  logic exp_m [4096];
  int n_fail = 0;
  int checks = 0;
  wire dq = o_pins.din_oen ? mdq : o_pins.din;
  initial forever #50 i_mclk = ~i_mclk;
  csr_host dut_u (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid),
    .o_rsp_data(o_rsp_data), .o_pins(o_pins), .i_dout(dq), .i_cycle_progress_flag(flag));
  csr_mem_model mem_u (.i_mclk(i_mclk), .i_pins(o_pins), .i_dq(dq), .i_acc(acc),
    .o_dq(mdq), .o_flag(flag));
  task automatic chk(input string nm, input logic seen, input logic exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %b seen %b", nm, exp, seen);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic bound(input int n);
    if (n >= 99) begin
      chk("timeout", 1'b0, 1'b1);
      end_of_test();
    end
  endtask : bound
  task automatic xfer(input csr_pkg::csr_op_t op, input logic [11:0] ad, input logic d);
    int n;
    @(negedge i_mclk);
    i_req_valid = 1;
    i_req = '{op, ad, d};
    acc = 3'($urandom_range(1, 3));
    for (n = 0; n < 99 && o_req_ready !== 1'b1; n++) @(negedge i_mclk);
    bound(n);
    @(negedge i_mclk);
    i_req_valid = 0;
    if (op != csr_pkg::CSR_OP_WRITE) begin
      for (n = 0; n < 99 && o_rsp_valid !== 1'b1; n++) @(negedge i_mclk);
      bound(n);
      chk("rsp_data", o_rsp_data, exp_m[ad]);
    end
    if (op != csr_pkg::CSR_OP_READ) exp_m[ad] = d;
  endtask : xfer
  initial begin
    logic [11:0] ad [8];
    void'($urandom(76457));
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rstn = 1;
    for (int i = 0; i < 8; i++) begin
      // both ends of the address range first
      ad[i] = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($urandom);
      xfer(csr_pkg::CSR_OP_WRITE, ad[i], 1'($urandom));
      xfer(csr_pkg::CSR_OP_READ, ad[i], 1'b0);
    end
    $display("test write_read done");
    foreach (ad[i]) xfer(csr_pkg::CSR_OP_RMW, ad[i], !exp_m[ad[i]]);
    foreach (ad[i]) xfer(csr_pkg::CSR_OP_READ, ad[i], 1'b0);
    $display("test rmw done");
    end_of_test();
  end
endmodule : csr_host_tb
